// File: verilog/psr_pkg.sv
// Shared constants and carrier types for the position supervisor
package psr_pkg;
    // Register addresses on the plain register port (word addresses)
    localparam logic [7:0] ADR_CMD      = 8'h00;
    localparam logic [7:0] ADR_MODE     = 8'h01;
    localparam logic [7:0] ADR_STATUS   = 8'h02;
    localparam logic [7:0] ADR_VSTAT    = 8'h03;
    localparam logic [7:0] ADR_TWIN     = 8'h04;
    localparam logic [7:0] ADR_TDWELL   = 8'h05;
    localparam logic [7:0] ADR_SSWIN0   = 8'h06;
    localparam logic [7:0] ADR_SSWIN1   = 8'h07;
    localparam logic [7:0] ADR_LAGWIN   = 8'h08;
    localparam logic [7:0] ADR_SCALE    = 8'h09;
    localparam logic [7:0] ADR_LAGERR   = 8'h0A;
    localparam logic [7:0] ADR_POS_INC  = 8'h0B;
    localparam logic [7:0] ADR_POS_USR  = 8'h0C;
    localparam logic [7:0] ADR_SPDLIM   = 8'h0D;
    localparam logic [7:0] ADR_AREA0    = 8'h10;
    localparam logic [7:0] ADR_AREA5    = 8'h15;
    localparam logic [7:0] ADR_REFMETH  = 8'h16;
    localparam logic [7:0] ADR_REFSPD   = 8'h17;
    localparam logic [7:0] ADR_REFPOS   = 8'h18;
    // Mode codes and bit positions
    localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
    localparam logic [7:0] MODE_REFERENCE   = 8'h06;
    localparam int CMD_REF_START   = 4;
    localparam int CMD_FAULT_RESET = 7;
    localparam int ST_TARGET       = 10;
    localparam int ST_REF_DONE     = 12;
    localparam int ST_REF_ERR      = 13;
    localparam int ST_CTL_ON       = 14;
    localparam int ST_LAG_FAULT    = 3;
    localparam int VST_REFERENCED  = 24;
    // Reset values and fixed readbacks
    localparam logic [15:0] WIN_MAX       = 16'hFFFF;
    localparam logic [15:0] TWIN_RST      = 16'h000A;
    localparam logic [15:0] TDWELL_RST    = 16'h0064;
    localparam logic [15:0] SSWIN0_RST    = 16'hFFFF;
    localparam logic [15:0] SSWIN1_RST    = 16'hFFFF;
    localparam logic [15:0] LAGWIN_RST    = 16'h0100;
    localparam logic [15:0] SPDLIM_RST    = 16'h0010;
    localparam logic [4:0]  SCALE_RST     = 5'h00;
    localparam logic [31:0] REF_METHOD_RO = 32'hFFFFFFFF;
    // Dwell timing: one tick per millisecond at the 25 ns system clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // One area: minimum in entry 0, maximum in entry 1
    typedef struct packed {
        logic signed [31:0] max_lim;
        logic signed [31:0] min_lim;
    } psr_area_t;

    // Working, traversing and safety areas
    typedef struct packed {
        psr_area_t safety;
        psr_area_t traverse;
        psr_area_t working;
    } psr_areas_t;

    // Supervision states
    typedef enum logic [1:0] {
        ST_MOVING  = 2'b00,
        ST_SETTLED = 2'b01,
        ST_RELAXED = 2'b10
    } psr_state_t;
endpackage

// File: verilog/psr_supervisor.sv
// Position supervision, standstill control release and referencing
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Compare target and actual position continuously
// - Target reached after window dwell below speed limit
// - Maximum target window: finish after standstill time
// - Standstill windows dormant until target reached
// - Dwell inside active window switches control off
// - Leaving inactive window re-enables position control
// - Release disabled: active > inactive or 65535
// - Standstill pair: entry 0 active, 1 inactive
// - Lag beyond window raises fault and shutdown in profile position mode with control on
// - Lag window given in user units, converted
// - Position reported in increments and user units
// - Referencing mode selectable only with power off
// - Limits locked while on; change clears reference
// - Referencing only on rising command bit 4
// - Completed referencing sets vendor status bit 24
// - Reference method reads fixed -1
// - Reference speed stored but unused
// - Referencing establishes working, traversing, safety areas
// - Referencing loads reference value as position
// - Area limits: entry 0 minimum, 1 maximum
module psr_supervisor
    import psr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_we,
    input  wire logic               reg_re,
    output logic      [31:0]        reg_rdata,
    input  wire logic               drive_on,
    input  wire logic signed [31:0] target_position,
    input  wire logic signed [31:0] demand_position,
    input  wire logic signed [31:0] raw_increments,
    input  wire logic        [15:0] speed_abs,
    output logic                    target_reached,
    output logic                    posctl_enable,
    output logic                    lag_fault,
    output logic                    shutdown_req,
    output logic                    referenced,
    output psr_areas_t              areas
);
    // Software-visible configuration
    logic [15:0]        cmd_word;
    logic [7:0]         mode_sel;
    logic [15:0]        twin;
    logic [15:0]        tdwell;
    logic [15:0]        sswin_act;
    logic [15:0]        sswin_inact;
    logic [31:0]        lagwin_int;
    logic [4:0]         scale_sh;
    logic [15:0]        spd_lim;
    logic [31:0]        ref_speed;
    logic signed [31:0] ref_pos_val;
    logic signed [31:0] pos_offset;
    logic               ref_done;
    logic               ref_err;
    psr_state_t         state;
    psr_state_t         next_state;
    logic [15:0]        tw_cnt;
    logic [15:0]        aw_cnt;
    logic [31:0]        tick_div;
    logic signed [31:0] prev_target;

    // Bus decode
    wire wr_cmd    = reg_we && reg_addr == ADR_CMD;
    wire wr_mode   = reg_we && reg_addr == ADR_MODE;
    wire wr_area   = reg_we && reg_addr >= ADR_AREA0 && reg_addr <= ADR_AREA5;
    wire [2:0] area_idx = 3'(reg_addr - ADR_AREA0);

    // Millisecond tick for the dwell timers
    wire tick = tick_div == 32'(TICK_CYCLES - 1);

    // A new target is any step of the target input against last cycle's value
    wire target_moved = target_position != prev_target;

    // Position in increments after referencing, and in user units
    wire signed [31:0] pos_inc = raw_increments + pos_offset;
    wire signed [31:0] pos_usr = pos_inc >>> scale_sh;

    // Errors against target and demand
    wire signed [31:0] tgt_err = target_position - pos_inc;
    wire signed [31:0] lag_err = demand_position - pos_inc;
    wire [31:0] tgt_abs = tgt_err[31] ? 32'(-tgt_err) : 32'(tgt_err);
    wire [31:0] lag_abs = lag_err[31] ? 32'(-lag_err) : 32'(lag_err);

    // Window tests; a target window at its maximum checks only speed
    wire pos_mode  = mode_sel == MODE_PROFILE_POS;
    wire slow      = speed_abs < spd_lim;
    wire twin_max  = twin == WIN_MAX;
    wire in_twin   = twin_max || tgt_abs <= {16'h0000, twin};
    wire in_act    = tgt_abs <= {16'h0000, sswin_act};
    wire out_inact = tgt_abs > {16'h0000, sswin_inact};
    wire rel_en    = !(sswin_act > sswin_inact || sswin_act == WIN_MAX
                       || sswin_inact == WIN_MAX);
    wire tw_done   = tw_cnt >= tdwell;
    wire aw_done   = aw_cnt >= tdwell;
    wire lag_trip  = pos_mode && posctl_enable && lag_abs > lagwin_int;

    // Referencing trigger: only a 0 to 1 step of command bit 4 counts
    wire ref_edge  = wr_cmd && reg_wdata[CMD_REF_START] && !cmd_word[CMD_REF_START];
    wire ref_go    = ref_edge && mode_sel == MODE_REFERENCE;
    wire area_bad  = areas.working.min_lim > areas.working.max_lim
                     || areas.traverse.min_lim > areas.traverse.max_lim
                     || areas.safety.min_lim > areas.safety.max_lim;

    // Supervision state sequencing
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_MOVING:  if (pos_mode && in_twin && slow && tw_done) next_state = ST_SETTLED;
            ST_SETTLED: if (rel_en && in_act && aw_done) next_state = ST_RELAXED;
            ST_RELAXED: if (!rel_en || out_inact) next_state = ST_SETTLED;
            default:    next_state = ST_MOVING;
        endcase
        // Leaving the mode or a new target restarts supervision
        if (!pos_mode || target_moved || lag_fault) next_state = ST_MOVING;
    end

    always_comb
    begin
        target_reached = state != ST_MOVING;
        posctl_enable  = state != ST_RELAXED;
        shutdown_req   = lag_fault;
    end

    // Divider and state
    always_ff @(posedge clk_sys)
    begin
        if (!rstn) begin
            tick_div    <= 32'h00000000;
            state       <= ST_MOVING;
            prev_target <= 32'h00000000;
        end else begin
            tick_div    <= tick ? 32'h00000000 : tick_div + 32'h00000001;
            state       <= next_state;
            prev_target <= target_position;
        end
    end

    // Dwell timers restart as soon as their window is left
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || state != ST_MOVING || !(in_twin && slow)) tw_cnt <= 16'h0000;
        else if (tick && !tw_done) tw_cnt <= tw_cnt + 16'h0001;
        if (!rstn || state != ST_SETTLED || !in_act) aw_cnt <= 16'h0000;
        else if (tick && !aw_done) aw_cnt <= aw_cnt + 16'h0001;
    end

    // Lag fault is sticky until software resets it; a new trip wins
    always_ff @(posedge clk_sys)
    begin
        if (!rstn) lag_fault <= 1'b0;
        else if (lag_trip) lag_fault <= 1'b1;
        else if (wr_cmd && reg_wdata[CMD_FAULT_RESET]) lag_fault <= 1'b0;
    end

    // Command and mode registers
    always_ff @(posedge clk_sys)
    begin
        if (!rstn) begin
            cmd_word <= 16'h0000;
            mode_sel <= 8'h00;
        end else begin
            if (wr_cmd) cmd_word <= reg_wdata[15:0];
            // Referencing mode refused while the power stage is on
            if (wr_mode && !(reg_wdata[7:0] == MODE_REFERENCE && drive_on))
                mode_sel <= reg_wdata[7:0];
        end
    end

    // Parameters; the lag window is held in increments
    always_ff @(posedge clk_sys)
    begin
        if (!rstn) begin
            twin        <= TWIN_RST;
            tdwell      <= TDWELL_RST;
            sswin_act   <= SSWIN0_RST;
            sswin_inact <= SSWIN1_RST;
            lagwin_int  <= {16'h0000, LAGWIN_RST};
            scale_sh    <= SCALE_RST;
            spd_lim     <= SPDLIM_RST;
            ref_speed   <= 32'h00000000;
            ref_pos_val <= 32'h00000000;
        end else if (reg_we) begin
            unique case (reg_addr)
                ADR_TWIN:   twin        <= reg_wdata[15:0];
                ADR_TDWELL: tdwell      <= reg_wdata[15:0];
                ADR_SSWIN0: sswin_act   <= reg_wdata[15:0];
                ADR_SSWIN1: sswin_inact <= reg_wdata[15:0];
                ADR_LAGWIN: lagwin_int  <= {16'h0000, reg_wdata[15:0]} << scale_sh;
                ADR_SCALE:  scale_sh    <= reg_wdata[4:0];
                ADR_SPDLIM: spd_lim     <= reg_wdata[15:0];
                ADR_REFSPD: ref_speed   <= reg_wdata;
                ADR_REFPOS: ref_pos_val <= reg_wdata;
                default:    ;
            endcase
        end
    end

    // Area limits: locked while the drive is on
    always_ff @(posedge clk_sys)
    begin
        if (!rstn) begin
            areas <= '0;
        end else if (wr_area && !drive_on) begin
            unique case (area_idx)
                3'h0:    areas.working.min_lim  <= reg_wdata;
                3'h1:    areas.working.max_lim  <= reg_wdata;
                3'h2:    areas.traverse.min_lim <= reg_wdata;
                3'h3:    areas.traverse.max_lim <= reg_wdata;
                3'h4:    areas.safety.min_lim   <= reg_wdata;
                default: areas.safety.max_lim   <= reg_wdata;
            endcase
        end
    end

    // Referencing: loads the position and checks the three areas
    always_ff @(posedge clk_sys)
    begin
        if (!rstn) begin
            pos_offset <= 32'h00000000;
            ref_done   <= 1'b0;
            ref_err    <= 1'b0;
            referenced <= 1'b0;
        end else if (ref_go) begin
            pos_offset <= ref_pos_val - raw_increments;
            ref_done   <= !area_bad;
            ref_err    <= area_bad;
            referenced <= !area_bad;
        end else if (wr_area && !drive_on) begin
            referenced <= 1'b0;
            ref_done   <= 1'b0;
        end else if (wr_mode && mode_sel == MODE_REFERENCE) begin
            // Homing status is only meaningful in referencing mode
            ref_done <= ref_done && reg_wdata[7:0] == MODE_REFERENCE;
            ref_err  <= ref_err && reg_wdata[7:0] == MODE_REFERENCE;
        end
    end

    // Read mux; unmapped addresses read as zero
    wire [31:0] status_word = (32'(target_reached) << ST_TARGET)
                            | (32'(ref_done) << ST_REF_DONE)
                            | (32'(ref_err) << ST_REF_ERR)
                            | (32'(posctl_enable) << ST_CTL_ON)
                            | (32'(lag_fault) << ST_LAG_FAULT);
    wire [31:0] area_word = 32'(areas >> (32 * area_idx));
    wire [31:0] rd_mux =
        reg_addr == ADR_CMD     ? {16'h0000, cmd_word} :
        reg_addr == ADR_MODE    ? {24'h000000, mode_sel} :
        reg_addr == ADR_STATUS  ? status_word :
        reg_addr == ADR_VSTAT   ? 32'(referenced) << VST_REFERENCED :
        reg_addr == ADR_TWIN    ? {16'h0000, twin} :
        reg_addr == ADR_TDWELL  ? {16'h0000, tdwell} :
        reg_addr == ADR_SSWIN0  ? {16'h0000, sswin_act} :
        reg_addr == ADR_SSWIN1  ? {16'h0000, sswin_inact} :
        reg_addr == ADR_LAGWIN  ? lagwin_int :
        reg_addr == ADR_SCALE   ? {27'h0000000, scale_sh} :
        reg_addr == ADR_LAGERR  ? lag_err :
        reg_addr == ADR_POS_INC ? pos_inc :
        reg_addr == ADR_POS_USR ? pos_usr :
        reg_addr == ADR_SPDLIM  ? {16'h0000, spd_lim} :
        wr_area || (reg_addr >= ADR_AREA0 && reg_addr <= ADR_AREA5) ? area_word :
        reg_addr == ADR_REFMETH ? REF_METHOD_RO :
        reg_addr == ADR_REFSPD  ? ref_speed :
        reg_addr == ADR_REFPOS  ? ref_pos_val : 32'h00000000;

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || !reg_re) reg_rdata <= 32'h00000000;
        else reg_rdata <= rd_mux;
    end

    // Checks
    sequence s_ref_trigger;
        ref_go && !area_bad;
    endsequence
    sequence s_ref_loaded;
        referenced && pos_offset == $past(ref_pos_val) - $past(raw_increments);
    endsequence

    a_target_needs_dwell: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(target_reached) |-> $past(in_twin && slow && tw_done && pos_mode))
        else $error("target reached without dwell");
    a_release_dormant: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(posctl_enable) |-> $past(target_reached) && target_reached)
        else $error("control released before target reached");
    a_release_active: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(posctl_enable) |-> $past(in_act && aw_done && rel_en))
        else $error("control released outside active window");
    a_reengage_inact: assert property (@(posedge clk_sys) disable iff (!rstn)
        !posctl_enable && out_inact && pos_mode |=> posctl_enable)
        else $error("control not re-enabled outside inactive window");
    a_release_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        !rel_en |=> posctl_enable)
        else $error("control released while release disabled");
    a_lag_shutdown: assert property (@(posedge clk_sys) disable iff (!rstn)
        lag_trip |=> lag_fault && shutdown_req ##1 !target_reached)
        else $error("lag fault not raised");
    a_mode_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_mode && reg_wdata[7:0] == MODE_REFERENCE && drive_on |=> $stable(mode_sel))
        else $error("referencing mode taken while on");
    a_limits_locked: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_area && drive_on |=> $stable(areas))
        else $error("area limit changed while on");
    a_ref_edge_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(ref_done) |-> $past(ref_go))
        else $error("referencing without rising bit 4");
    a_ref_loads: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_ref_trigger |=> s_ref_loaded)
        else $error("reference value not loaded");
    a_dwell_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
        state == ST_MOVING && !(in_twin && slow) |=> tw_cnt == 16'h0000)
        else $error("dwell timer not restarted");
endmodule

`default_nettype wire

// File: sim/psr_host_model.sv
// Host controller model driving the register port of the supervisor
`timescale 1ns/1ps
`default_nettype none

module psr_host_model
    import psr_pkg::*;
(
    input  wire logic        clk_sys,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_we,
    output logic             reg_re,
    input  wire logic [31:0] reg_rdata
);
    // Idle values at time zero, strobes low
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h00000000;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
    end

    // One-cycle write; address and data are scrambled once released so stale values never match
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk_sys);
        reg_we    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // One-cycle read; data stands only in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk_sys);
        reg_re   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// File: sim/psr_testbench.sv
// Self-checking bench for the position supervisor and referencing logic
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); \
        end \
    end

module testbench
    import psr_pkg::*;
;
    localparam int TICKS = 4;
    logic               clk_sys = 1'b0;
    logic               rstn;
    logic        [7:0]  reg_addr;
    logic        [31:0] reg_wdata;
    logic               reg_we;
    logic               reg_re;
    logic        [31:0] reg_rdata;
    logic               drive_on;
    logic signed [31:0] target_position;
    logic signed [31:0] demand_position;
    logic signed [31:0] raw_increments;
    logic        [15:0] speed_abs;
    logic               target_reached;
    logic               posctl_enable;
    logic               lag_fault;
    logic               shutdown_req;
    logic               referenced;
    psr_areas_t         areas;
    int                 err_count = 0;
    int                 samples_checked = 0;
    int                 seed = 32'he79acecf;
    logic        [31:0] d;
    logic signed [31:0] base;
    logic signed [31:0] refv;
    logic signed [31:0] av [6];
    logic        [7:0]  ra [10] = '{ADR_MODE, ADR_TWIN, ADR_TDWELL, ADR_SSWIN0, ADR_SSWIN1,
                                   ADR_LAGWIN, ADR_SPDLIM, ADR_SCALE, ADR_REFMETH, 8'h3F};
    logic        [31:0] rv [10] = '{32'h0, 32'(TWIN_RST), 32'(TDWELL_RST), 32'(SSWIN0_RST),
                                   32'(SSWIN1_RST), 32'(LAGWIN_RST), 32'(SPDLIM_RST),
                                   32'(SCALE_RST), REF_METHOD_RO, 32'h0};

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    psr_supervisor #(.TICK_CYCLES(TICKS)) u_psr_supervisor (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .drive_on(drive_on),
        .target_position(target_position), .demand_position(demand_position),
        .raw_increments(raw_increments), .speed_abs(speed_abs),
        .target_reached(target_reached), .posctl_enable(posctl_enable),
        .lag_fault(lag_fault), .shutdown_req(shutdown_req), .referenced(referenced),
        .areas(areas)
    );

    psr_host_model u_host (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata)
    );

    // Status line picked by number so one wait task serves all three flags
    function automatic logic get(input int sel);
        case (sel)
            0:       return target_reached;
            1:       return posctl_enable;
            default: return lag_fault;
        endcase
    endfunction

    // Drive the motion-side inputs just after a rising edge
    task automatic drv(input logic on, input logic signed [31:0] r, t, dm, input logic [15:0] s);
        @(posedge clk_sys);
        drive_on        <= on;
        raw_increments  <= r;
        target_position <= t;
        demand_position <= dm;
        speed_abs       <= s;
    endtask

    // Wait for a flag under a bound, and insist it did not come earlier than lo cycles
    task automatic waitf(input int sel, input logic want, input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (get(sel) !== want && n < hi)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK(get(sel), want)
        `CHK(n >= lo, 1'b1)
    endtask

    // Flag must keep its value for n cycles
    task automatic hold(input int sel, input logic v, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n)
        begin
            @(posedge clk_sys);
            #1;
            if (get(sel) !== v)
                ok = 1'b0;
        end
        `CHK(ok, 1'b1)
    endtask

    task automatic print_verdict();
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under two thousand cycles
    initial
    begin
        #(20000 * 25);
        err_count++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        rstn = 1'b0;
        drive_on = 1'b0;
        target_position = 0;
        demand_position = 0;
        raw_increments = 0;
        speed_abs = 16'h0000;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        `CHK(posctl_enable, 1'b1)
        `CHK(target_reached, 1'b0)
        for (int i = 0; i < 10; i++)
        begin
            u_host.rd(ra[i], d);
            `CHK(d, rv[i])
        end
        // Positioning: slow speed is needed before the window dwell counts
        base = $random(seed) & 32'h000FFFFF;
        drv(1'b1, base, base, base, 16'h0064);
        u_host.wr(ADR_TDWELL, 32'h5);
        u_host.wr(ADR_SSWIN0, 32'h5);
        u_host.wr(ADR_SSWIN1, 32'h14);
        u_host.wr(ADR_MODE, 32'(MODE_PROFILE_POS));
        hold(0, 1'b0, 30);
        `CHK(posctl_enable, 1'b1)
        drv(1'b1, base, base, base, 16'h0000);
        waitf(0, 1'b1, 12, 60);
        `CHK(posctl_enable, 1'b1)
        waitf(1, 1'b0, 8, 80);
        drv(1'b1, base + 30, base, base, 16'h0000);
        waitf(1, 1'b1, 0, 4);
        // Active above inactive turns the release off
        u_host.wr(ADR_SSWIN0, 32'h1E);
        drv(1'b1, base + 30, base + 30, base + 30, 16'h0000);
        repeat (12) @(posedge clk_sys);
        #1;
        `CHK(target_reached, 1'b0)
        drv(1'b1, base + 45, base + 30, base + 30, 16'h0000);
        drv(1'b1, base + 45, base + 30, base + 30, 16'h0000);
        drv(1'b1, base + 30, base + 30, base + 30, 16'h0000);
        waitf(0, 1'b1, 12, 60);
        hold(1, 1'b1, 60);
        // Lag exactly at the window edge is tolerated, one more trips
        drv(1'b1, base + 30, base + 30, base + 286, 16'h0000);
        hold(2, 1'b0, 6);
        drv(1'b1, base + 30, base + 30, base + 287, 16'h0000);
        waitf(2, 1'b1, 0, 4);
        `CHK(shutdown_req, 1'b1)
        drv(1'b1, base + 30, base + 30, base + 30, 16'h0000);
        u_host.wr(ADR_CMD, 32'h80);
        waitf(2, 1'b0, 0, 3);
        u_host.wr(ADR_TWIN, 32'h0000FFFF);
        // Target far outside any window: only the maximum window lets it finish
        drv(1'b1, base + 30, base + 5030, base + 30, 16'h0000);
        waitf(0, 1'b1, 12, 60);
        // Referencing mode only with the power stage off
        u_host.wr(ADR_MODE, 32'(MODE_REFERENCE));
        u_host.rd(ADR_MODE, d);
        `CHK(d, 32'(MODE_PROFILE_POS))
        drv(1'b0, base + 30, base + 5030, base + 30, 16'h0000);
        u_host.wr(ADR_MODE, 32'(MODE_REFERENCE));
        u_host.rd(ADR_MODE, d);
        `CHK(d, 32'(MODE_REFERENCE))
        for (int i = 0; i < 6; i++)
        begin
            av[i] = (i % 2) ? av[i-1] + ($random(seed) & 32'hFFFF) + 1 : $random(seed) >>> 8;
            u_host.wr(ADR_AREA0 + 8'(i), av[i]);
        end
        refv = $random(seed);
        u_host.wr(ADR_REFPOS, refv);
        u_host.wr(ADR_CMD, 32'h10);
        #1;
        `CHK(referenced, 1'b1)
        u_host.rd(ADR_VSTAT, d);
        `CHK(d[VST_REFERENCED], 1'b1)
        u_host.rd(ADR_STATUS, d);
        `CHK(d[ST_REF_DONE +: 2], 2'b01)
        u_host.rd(ADR_POS_INC, d);
        `CHK(d, refv)
        `CHK({areas.working, areas.traverse, areas.safety},
             {av[1], av[0], av[3], av[2], av[5], av[4]})
        u_host.wr(ADR_SCALE, 32'h3);
        u_host.rd(ADR_POS_USR, d);
        `CHK(d, 32'(refv >>> 3))
        u_host.wr(ADR_LAGWIN, 32'd50);
        u_host.rd(ADR_LAGWIN, d);
        `CHK(d, 32'd400)
        u_host.wr(ADR_REFSPD, refv ^ base);
        u_host.rd(ADR_REFSPD, d);
        `CHK(d, 32'(refv ^ base))
        u_host.wr(ADR_REFMETH, 32'h0);
        u_host.rd(ADR_REFMETH, d);
        `CHK(d, REF_METHOD_RO)
        // Limits are locked while on; an accepted change drops the reference
        drv(1'b1, base + 30, base + 5030, base + 30, 16'h0000);
        u_host.wr(ADR_AREA0, av[0] - 1);
        u_host.rd(ADR_AREA0, d);
        `CHK(d, av[0])
        `CHK(referenced, 1'b1)
        drv(1'b0, base + 30, base + 5030, base + 30, 16'h0000);
        u_host.wr(ADR_AREA0, av[0] - 1);
        #1;
        `CHK(referenced, 1'b0)
        u_host.wr(ADR_CMD, 32'h10);
        #1;
        `CHK(referenced, 1'b0)
        u_host.wr(ADR_CMD, 32'h0);
        u_host.wr(ADR_CMD, 32'h10);
        #1;
        `CHK(referenced, 1'b1)
        // Minimum above maximum makes referencing fail
        u_host.wr(ADR_AREA0, av[1] + 1);
        u_host.wr(ADR_CMD, 32'h0);
        u_host.wr(ADR_CMD, 32'h10);
        u_host.rd(ADR_STATUS, d);
        `CHK(d[ST_REF_DONE +: 2], 2'b10)
        `CHK(referenced, 1'b0)
        print_verdict();
    end
endmodule

`default_nettype wire
